// file: verification/tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module tb_top import uart_sfc_pkg::*;;
  logic i_core_clk = 1'b0, i_resetn = 1'b0, i_cs = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
  logic o_int, i_rx, o_tx, o_baud_x16_out;
  logic [2:0] i_addr = 3'h0;
  logic [7:0] i_wdata = 8'h00, o_rdata, v, d;
  logic [7:0] x [4];
  logic [31:0] lfsr = 32'd93165;
  longint t;
  int n_errors = 0, checked = 0;
  always #25 i_core_clk = ~i_core_clk;
  uart_sfc_top i_dut (.i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_cs(i_cs), .i_wr(i_wr), .i_rd(i_rd),
    .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata), .o_int(o_int), .i_rx(i_rx), .o_tx(o_tx),
    .o_baud_x16_out(o_baud_x16_out));
  uart_line_model i_line (.i_clk(i_core_clk), .i_tx(o_tx), .o_rx(i_rx));
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction
  function automatic logic [7:0] interrupt_status_reg(input logic f, input logic [5:0] id);
    return {f, f, id};
  endfunction
  task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] dt);
    {i_cs, i_wr, i_rd, i_addr, i_wdata} <= {1'b1, w, !w, a, dt};
    @(posedge i_core_clk);
    #2 v = o_rdata;
    {i_cs, i_wr, i_rd} <= 3'h0;
    @(posedge i_core_clk);
    #2;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_core_clk);
    #2;
  endtask
  task automatic got(input logic [7:0] e);
    logic [7:0] g;
    for (int i = 0; i < 3000 && i_line.got_q.size() == 0; i++) cyc(1);
    // Nothing arrived in time: force a mismatch rather than pop an empty queue
    g = (i_line.got_q.size() != 0) ? i_line.got_q.pop_front() : ~e;
    `CHK("tx", e, g)
  endtask
  task automatic enhanced_feature_reg(input logic [7:0] e);
    acc(1, A_LCR, ENH_KEY);
    acc(1, A_EFR, e);
    acc(1, A_LCR, 8'h03);
  endtask
  task automatic test_done();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    cyc(8);
    i_resetn = 1'b1;
    acc(1, A_LCR, ENH_KEY);
    for (int i = 0; i < 4; i++) begin
      acc(0, 3'(i + 4), 8'h00);
      `CHK("xrst", 8'h00, v)
      d = rnd();
      x[i] = {1'b0, d[6:2], 2'(i)};
      acc(1, 3'(i + 4), x[i]);
      acc(0, 3'(i + 4), 8'h00);
      `CHK("xchr", x[i], v)
    end
    `CHK("boff", 1'b0, o_baud_x16_out)
    acc(1, A_DIVL, 8'h02);
    acc(1, A_DIVH, 8'h01);
    acc(0, A_DIVH, 8'h00);
    // Skip the first gap, it straddles the divisor change
    @(posedge o_baud_x16_out);
    @(posedge o_baud_x16_out);
    t = $time;
    @(posedge o_baud_x16_out);
    `CHK("bper", 64'd12900, $time - t)
    acc(1, A_DIVL, 8'h01);
    acc(1, A_DIVH, 8'h00);
    $display("test regs done");
    enhanced_feature_reg(8'h01);
    acc(0, A_LCR, 8'h00);
    acc(1, A_IER, 8'h20);
    i_line.send(x[2]);
    cyc(20);
    `CHK("pint", 1'b1, o_int)
    d = rnd();
    acc(1, A_DATA, d);
    cyc(400);
    `CHK("held", 0, i_line.got_q.size())
    i_line.send(x[0]);
    got(d);
    acc(0, A_ISR, 8'h00);
    `CHK("pclr", interrupt_status_reg(1'b0, IID_NONE), v)
    // Seven-bit words: the set top bit lies outside the compare and acts as stop
    acc(1, A_LCR, 8'h02);
    i_line.send(x[2] | 8'h80);
    cyc(20);
    acc(0, A_ISR, 8'h00);
    `CHK("wl7", interrupt_status_reg(1'b0, IID_XOFF), v)
    i_line.send(x[0] | 8'h80);
    acc(0, A_LSR, 8'h00);
    `CHK("wl7r", 1'b0, v[LSR_DR])
    enhanced_feature_reg(8'h03);
    i_line.send(x[2]);
    i_line.send(x[3] ^ 8'h80);
    cyc(20);
    acc(0, A_DATA, 8'h00);
    `CHK("miss1", x[2], v)
    acc(0, A_DATA, 8'h00);
    `CHK("miss2", x[3] ^ 8'h80, v)
    i_line.send(x[2]);
    i_line.send(x[3]);
    acc(1, A_DATA, d);
    cyc(400);
    `CHK("dheld", 0, i_line.got_q.size())
    i_line.send(x[0]);
    i_line.send(x[1]);
    got(d);
    acc(0, A_LSR, 8'h00);
    `CHK("nost", 1'b0, v[LSR_DR])
    enhanced_feature_reg(8'h20);
    i_line.send(x[3]);
    cyc(20);
    acc(0, A_ISR, 8'h00);
    `CHK("sisr", interrupt_status_reg(1'b0, IID_XOFF), v)
    acc(0, A_DATA, 8'h00);
    `CHK("sdat", x[3], v)
    $display("test flow done");
    enhanced_feature_reg(8'h04);
    acc(1, A_ISR, 8'h01);
    d = rnd();
    i_line.send(d);
    i_line.send(~d);
    got(x[2]);
    acc(0, A_DATA, 8'h00);
    `CHK("rx1", d, v)
    acc(0, A_DATA, 8'h00);
    `CHK("rx2", ~d, v)
    got(x[0]);
    acc(1, A_IER, 8'h00);
    i_line.send(d);
    acc(1, A_IER, 8'h03);
    acc(0, A_IER, 8'h00);
    `CHK("int", 1'b1, o_int)
    acc(0, A_ISR, 8'h00);
    `CHK("prx", interrupt_status_reg(1'b1, IID_RX), v)
    acc(0, A_DATA, 8'h00);
    acc(0, A_ISR, 8'h00);
    `CHK("pthr", interrupt_status_reg(1'b1, IID_THR), v)
    cyc(700);
    acc(0, A_ISR, 8'h00);
    `CHK("nto", interrupt_status_reg(1'b1, IID_NONE), v)
    acc(1, A_ISR, 8'h41);
    i_line.send(d);
    cyc(630);
    acc(0, A_ISR, 8'h00);
    `CHK("to0", interrupt_status_reg(1'b1, IID_NONE), v)
    cyc(10);
    acc(0, A_ISR, 8'h00);
    `CHK("to1", interrupt_status_reg(1'b1, IID_TO), v)
    $display("test irq done");
    test_done();
  end
  initial begin
    #1000000;
    n_errors++;
    test_done();
  end
endmodule

// file: verification/uart_line_model.sv
`timescale 1ns/1ps
module uart_line_model (
  input wire logic i_clk,
  input wire logic i_tx,
  output logic o_rx
);
  logic [7:0] got_q [$];
  logic [7:0] b;
  initial o_rx = 1'b1;
  // Far side frames 8N1 at 16 core cycles a bit; line idles high
  task automatic send(input logic [7:0] c);
    for (int i = 0; i < 10; i++) begin
      o_rx <= i == 0 ? 1'b0 : i == 9 ? 1'b1 : c[i - 1];
      repeat (16) @(posedge i_clk);
      #2;
    end
  endtask
  always begin
    @(negedge i_tx);
    repeat (8) @(posedge i_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (16) @(posedge i_clk);
      b[i] = i_tx;
    end
    repeat (16) @(posedge i_clk);
    got_q.push_back(b);
  end
endmodule

// file: verification/uart_sfc_checker.sv
`timescale 1ns/1ps
module uart_sfc_checker import uart_sfc_pkg::*; (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_cs,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] o_rdata,
  input wire logic o_int,
  input wire logic i_rx,
  input wire logic o_tx,
  input wire logic o_baud_x16_out
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  logic [7:0] lcr_q, ier_q;
  logic [15:0] div_q;
  logic [3:0][7:0] xc_q;
  logic [8:0] low_q;
  wire logic wr = i_cs && i_wr;
  wire logic rd = i_cs && i_rd;
  wire logic enh = lcr_q == ENH_KEY;
  wire logic dl = lcr_q[LCR_DLAB];
  // Shadow of the host view; a low run is a whole number of bits only at divisor 1
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      {lcr_q, ier_q, div_q, xc_q, low_q} <= '0;
    end else begin
      low_q <= o_tx ? 9'h000 : low_q + 9'h001;
      if (wr && i_addr == A_LCR) lcr_q <= i_wdata;
      if (wr && !dl && i_addr == A_IER) ier_q <= i_wdata;
      if (wr && dl && i_addr[2:1] == 2'b00) div_q[8*i_addr[0] +: 8] <= i_wdata;
      if (wr && enh && i_addr[2]) xc_q[i_addr[1:0]] <= i_wdata;
    end
  end
  property p_xrd; rd && enh && i_addr[2] |=> o_rdata == $past(xc_q[i_addr[1:0]]); endproperty
  a_xrd: assert property (p_xrd) else $error("xchar read");
  property p_drd; rd && dl && i_addr[2:1] == 2'b00 |=> o_rdata == $past(div_q[8*i_addr[0] +: 8]); endproperty
  a_drd: assert property (p_drd) else $error("divisor read");
  property p_lrd; rd && !enh && i_addr == A_LCR |=> o_rdata == $past(lcr_q); endproperty
  a_lrd: assert property (p_lrd) else $error("lcr read");
  property p_ird; rd && !dl && i_addr == A_IER |=> o_rdata == $past(ier_q); endproperty
  a_ird: assert property (p_ird) else $error("ier read");
  property p_noint; ier_q == 8'h00 && $past(ier_q) == 8'h00 |-> !o_int; endproperty
  a_noint: assert property (p_noint) else $error("int while disabled");
  property p_boff; div_q == 16'h0000 && $past(div_q) == 16'h0000 |-> !o_baud_x16_out; endproperty
  a_boff: assert property (p_boff) else $error("baud at zero");
  property p_bpul; o_baud_x16_out && div_q > 16'h0001 && $stable(div_q) |=> !o_baud_x16_out || $changed(div_q); endproperty
  a_bpul: assert property (p_bpul) else $error("baud pulse");
  property p_tbit; $rose(o_tx) && div_q == 16'h0001 |-> low_q[3:0] == 4'h0 && low_q != 9'h000; endproperty
  a_tbit: assert property (p_tbit) else $error("tx bit length");
  cover property (rd && enh && i_addr[2]);
  cover property (o_baud_x16_out && div_q > 16'h0001);
  cover property ($rose(o_tx) && div_q == 16'h0001);
endmodule
bind uart_sfc_top uart_sfc_checker i_chk (.i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_cs(i_cs),
  .i_wr(i_wr), .i_rd(i_rd), .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata), .o_int(o_int),
  .i_rx(i_rx), .o_tx(o_tx), .o_baud_x16_out(o_baud_x16_out));

// file: verilog/uart_sfc_pkg.sv
package uart_sfc_pkg;

  // ************************************************************
  // Register addresses
  // ************************************************************
  localparam logic [2:0] A_DATA = 3'h0;
  localparam logic [2:0] A_IER = 3'h1;
  localparam logic [2:0] A_ISR = 3'h2;
  localparam logic [2:0] A_LCR = 3'h3;
  localparam logic [2:0] A_MCR = 3'h4;
  localparam logic [2:0] A_LSR = 3'h5;
  localparam logic [2:0] A_MSR = 3'h6;
  localparam logic [2:0] A_SPR = 3'h7;
  localparam logic [2:0] A_DIVL = 3'h0;
  localparam logic [2:0] A_DIVH = 3'h1;
  localparam logic [2:0] A_EFR = 3'h2;
  localparam logic [7:0] ENH_KEY = 8'hbf;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [7:0] CHAR_RST = 8'h00;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int LCR_STB = 2;
  localparam int LCR_PEN = 3;
  localparam int LCR_EPS = 4;
  localparam int LCR_DLAB = 7;
  localparam int IER_RX = 0;
  localparam int IER_THR = 1;
  localparam int IER_LS = 2;
  localparam int IER_PAUSE = 5;
  localparam int EFR_SPECIAL = 5;
  localparam int FCR_EN = 0;
  localparam int FCR_RXRST = 1;
  localparam int FCR_TXRST = 2;
  localparam int LSR_DR = 0;
  localparam int LSR_OE = 1;
  localparam int LSR_FE = 3;
  localparam int LSR_THRE = 5;
  localparam int LSR_TEMT = 6;

  // ************************************************************
  // Interrupt identification codes, bit 0 low means pending
  // ************************************************************
  localparam logic [5:0] IID_NONE = 6'h01;
  localparam logic [5:0] IID_LS = 6'h06;
  localparam logic [5:0] IID_RX = 6'h04;
  localparam logic [5:0] IID_TO = 6'h0c;
  localparam logic [5:0] IID_THR = 6'h02;
  localparam logic [5:0] IID_XOFF = 6'h10;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int TICKS_PER_BIT = 16;
  localparam int TIMEOUT_CHARS = 4;
  localparam int MAX_OSC_HZ = 48_000_000;
  localparam int CORE_CLK_HZ = 20_000_000;

  typedef enum logic [1:0] {FLOW_OFF = 2'b00, FLOW_FIRST = 2'b01, FLOW_SECOND = 2'b10, FLOW_DOUBLE = 2'b11} flow_mode_t;
  typedef enum logic [4:0] {ST_IDLE = 5'b00001, ST_START = 5'b00010, ST_DATA = 5'b00100, ST_PAR = 5'b01000,
                            ST_STOP = 5'b10000} ser_state_t;

endpackage

// file: verilog/uart_sfc_top.sv
`timescale 1ns/1ps

// ************************************************************
// FIFO
// ************************************************************
module uart_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_clear,
  // Fill side
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  // Drain side
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data,
  output logic [$clog2(DEPTH+1)-1:0] o_count
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr_q, rptr_q;
  logic [CW-1:0] count_q;
  wire push = i_valid & o_ready;
  wire pop = o_valid & i_ready;
  wire [AW-1:0] wptr_n = (wptr_q == AW'(DEPTH - 1)) ? '0 : AW'(wptr_q + 1'b1);
  wire [AW-1:0] rptr_n = (rptr_q == AW'(DEPTH - 1)) ? '0 : AW'(rptr_q + 1'b1);
  assign o_ready = count_q != CW'(DEPTH);
  assign o_valid = count_q != '0;
  assign o_data = mem[rptr_q];
  assign o_count = count_q;

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wptr_q] <= i_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wptr_q <= '0;
      rptr_q <= '0;
      count_q <= '0;
    end else if (i_clear) begin
      wptr_q <= '0;
      rptr_q <= '0;
      count_q <= '0;
    end else begin
      wptr_q <= push ? wptr_n : wptr_q;
      rptr_q <= pop ? rptr_n : rptr_q;
      count_q <= CW'(count_q + CW'(push) - CW'(pop));
    end
  end
endmodule

// ************************************************************
// Transceiver with soft flow control
// ************************************************************
module uart_sfc_top import uart_sfc_pkg::*; #(
  parameter int RX_DEPTH = 16,
  parameter int TX_DEPTH = 8
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_resetn,
  // Host register port
  input wire logic i_cs,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  output logic o_int,
  // Serial line
  input wire logic i_rx,
  output logic o_tx,
  output logic o_baud_x16_out
);
  localparam int RCW = $clog2(RX_DEPTH + 1);

  function automatic logic [7:0] trig_level(input logic [1:0] sel);
    case (sel)
      2'b00: trig_level = 8'd1;
      2'b01: trig_level = 8'd4;
      2'b10: trig_level = 8'd8;
      default: trig_level = 8'd14;
    endcase
  endfunction

  function automatic logic same(input logic [7:0] a, input logic [7:0] b, input logic [7:0] m);
    same = ((a ^ b) & m) == 8'h00;
  endfunction

  logic [7:0] ier_q, lcr_q, fcr_q, efr_q, mcr_q, spr_q, dll_q, dlm_q;
  logic [7:0] xch_q [4];
  logic [15:0] bcnt_q;
  logic rx_s1_q, rx_s2_q, rx_done_q, fe_q, oe_q;
  ser_state_t rx_st_q, tx_st_q;
  logic [3:0] rx_cnt_q;
  logic [5:0] tx_cnt_q;
  logic [2:0] rx_bit_q, tx_bit_q;
  logic [7:0] rx_sh_q, tx_sh_q, hold_ch_q, extra_ch_q;
  logic hold_q, hold_pause_q, extra_q, paused_q, sent_pause_q, flow_second_q;
  logic thr_pend_q, xoff_flag_q, tx_valid_prev_q;
  logic [9:0] to_cnt_q;

  // ************************************************************
  // Register decode
  // ************************************************************
  wire wr = i_cs & i_wr;
  wire rd = i_cs & i_rd;
  wire enh = lcr_q == ENH_KEY;
  wire sel_div = lcr_q[LCR_DLAB] & (i_addr == A_DIVL | i_addr == A_DIVH);
  wire sel_x = enh & i_addr[2];
  wire sel_efr = enh & (i_addr == A_EFR);
  wire sel_gen = !sel_div & !sel_x & !sel_efr;
  wire thr_wr = wr & sel_gen & (i_addr == A_DATA);
  wire fcr_wr = wr & sel_gen & (i_addr == A_ISR);
  wire rhr_rd = rd & sel_gen & (i_addr == A_DATA);
  wire isr_rd = rd & sel_gen & (i_addr == A_ISR);
  wire lsr_rd = rd & sel_gen & (i_addr == A_LSR);
  wire [1:0] wl = lcr_q[1:0];
  wire [7:0] wmask = 8'hff >> (2'd3 - wl);
  wire [2:0] last_bit = {1'b1, wl};
  wire [5:0] stop_ticks = !lcr_q[LCR_STB] ? 6'd16 : (wl == 2'b00) ? 6'd24 : 6'd32;
  wire [1:0] rx_mode = efr_q[1:0];
  wire [1:0] tx_mode = efr_q[3:2];

  // ************************************************************
  // Configuration registers
  // ************************************************************
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ier_q <= REG_RST;
      lcr_q <= REG_RST;
      fcr_q <= REG_RST;
      efr_q <= REG_RST;
      mcr_q <= REG_RST;
      spr_q <= REG_RST;
      dll_q <= REG_RST;
      dlm_q <= REG_RST;
      for (int i = 0; i < 4; i++) begin
        xch_q[i] <= CHAR_RST;
      end
    end else if (wr) begin
      if (sel_div & i_addr[0]) dlm_q <= i_wdata;
      if (sel_div & !i_addr[0]) dll_q <= i_wdata;
      if (sel_x) xch_q[i_addr[1:0]] <= i_wdata;
      if (sel_efr) efr_q <= i_wdata;
      if (sel_gen & i_addr == A_IER) ier_q <= i_wdata;
      if (fcr_wr) fcr_q <= i_wdata & ~8'h06;
      if (sel_gen & i_addr == A_LCR) lcr_q <= i_wdata;
      if (sel_gen & i_addr == A_MCR) mcr_q <= i_wdata;
      if (sel_gen & i_addr == A_SPR) spr_q <= i_wdata;
    end
  end

  // ************************************************************
  // Baud generator
  // ************************************************************
  wire [15:0] divisor = {dlm_q, dll_q};
  wire baud_en = divisor != 16'h0000;
  wire tick = baud_en & (bcnt_q >= divisor - 16'h0001);

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      bcnt_q <= 16'h0000;
      o_baud_x16_out <= 1'b0;
    end else begin
      bcnt_q <= (tick | !baud_en) ? 16'h0000 : bcnt_q + 16'h0001;
      o_baud_x16_out <= tick;
    end
  end

  // ************************************************************
  // Receiver
  // ************************************************************
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
      rx_st_q <= ST_IDLE;
      rx_cnt_q <= 4'h0;
      rx_bit_q <= 3'h0;
      rx_sh_q <= 8'h00;
      rx_done_q <= 1'b0;
    end else begin
      rx_s1_q <= i_rx;
      rx_s2_q <= rx_s1_q;
      rx_done_q <= 1'b0;
      if (tick) begin
        rx_cnt_q <= rx_cnt_q + 4'h1;
        case (rx_st_q)
          ST_IDLE: begin
            rx_cnt_q <= 4'h0;
            if (!rx_s2_q) rx_st_q <= ST_START;
          end
          ST_START: begin
            if (rx_cnt_q == 4'h7) begin
              rx_cnt_q <= 4'h0;
              rx_bit_q <= 3'h0;
              rx_sh_q <= 8'h00;
              rx_st_q <= rx_s2_q ? ST_IDLE : ST_DATA;
            end
          end
          ST_DATA: begin
            if (rx_cnt_q == 4'hf) begin
              rx_sh_q[rx_bit_q] <= rx_s2_q;
              rx_bit_q <= rx_bit_q + 3'h1;
              if (rx_bit_q == last_bit) rx_st_q <= lcr_q[LCR_PEN] ? ST_PAR : ST_STOP;
            end
          end
          ST_PAR: begin
            if (rx_cnt_q == 4'hf) rx_st_q <= ST_STOP;
          end
          ST_STOP: begin
            if (rx_cnt_q == 4'hf) begin
              rx_done_q <= 1'b1;
              rx_st_q <= ST_IDLE;
            end
          end
          default: rx_st_q <= ST_IDLE;
        endcase
      end
    end
  end

  // ************************************************************
  // Flow character recognition
  // ************************************************************
  wire [7:0] ch = rx_sh_q & wmask;
  wire flow_on = !efr_q[EFR_SPECIAL] & (rx_mode != FLOW_OFF);
  wire dbl = rx_mode == FLOW_DOUBLE;
  wire is_res1 = same(ch, (rx_mode == FLOW_SECOND) ? xch_q[1] : xch_q[0], wmask);
  wire is_pau1 = same(ch, (rx_mode == FLOW_SECOND) ? xch_q[3] : xch_q[2], wmask);
  wire second_ok = same(ch, hold_pause_q ? xch_q[3] : xch_q[1], wmask);
  wire take_single = rx_done_q & flow_on & !dbl & (is_res1 | is_pau1);
  wire take_pair = rx_done_q & flow_on & dbl & hold_q & second_ok;
  wire break_pair = rx_done_q & flow_on & dbl & hold_q & !second_ok;
  wire start_pair = rx_done_q & flow_on & dbl & !hold_q & (is_res1 | is_pau1);
  wire plain = rx_done_q & !(take_single | take_pair | break_pair | start_pair);
  wire pause_hit = take_single & is_pau1 | take_pair & hold_pause_q;
  wire resume_hit = take_single & !is_pau1 | take_pair & !hold_pause_q;
  wire special_hit = rx_done_q & efr_q[EFR_SPECIAL] & same(ch, xch_q[3], wmask);
  wire push_v = plain | break_pair | extra_q;
  wire [7:0] push_d = break_pair ? hold_ch_q : extra_q ? extra_ch_q : ch;

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      hold_q <= 1'b0;
      hold_pause_q <= 1'b0;
      hold_ch_q <= 8'h00;
      extra_q <= 1'b0;
      extra_ch_q <= 8'h00;
      paused_q <= 1'b0;
    end else begin
      hold_q <= start_pair | (hold_q & !rx_done_q & dbl & flow_on);
      hold_pause_q <= start_pair ? is_pau1 : hold_pause_q;
      hold_ch_q <= start_pair ? ch : hold_ch_q;
      extra_q <= break_pair;
      extra_ch_q <= break_pair ? ch : extra_ch_q;
      paused_q <= pause_hit | (paused_q & !resume_hit & rx_mode != FLOW_OFF);
    end
  end

  // ************************************************************
  // Data FIFOs
  // ************************************************************
  logic rx_ready, rx_valid, tx_valid;
  logic [7:0] rx_data, tx_data;
  logic [RCW-1:0] rx_count;
  wire [7:0] rx_cnt8 = 8'(rx_count);
  wire [7:0] trig = trig_level(fcr_q[7:6]);
  wire over = rx_cnt8 > trig;
  wire under = rx_cnt8 < trig;
  wire tx_idle = (tx_st_q == ST_IDLE) & baud_en;
  wire fl_sec = tx_idle & flow_second_q;
  wire fl_pau = tx_idle & !flow_second_q & (tx_mode != FLOW_OFF) & !sent_pause_q & over;
  wire fl_res = tx_idle & !flow_second_q & sent_pause_q & under;
  wire tx_take = tx_idle & !flow_second_q & !fl_pau & !fl_res & tx_valid & !paused_q;
  wire tx_load = fl_sec | fl_pau | fl_res | tx_take;
  wire [7:0] tx_char = fl_sec ? (sent_pause_q ? xch_q[3] : xch_q[1]) :
                       fl_pau ? ((tx_mode == FLOW_SECOND) ? xch_q[3] : xch_q[2]) :
                       fl_res ? ((tx_mode == FLOW_SECOND) ? xch_q[1] : xch_q[0]) : tx_data;

  uart_fifo #(.WIDTH(8), .DEPTH(RX_DEPTH)) u_rx_fifo (
    .i_clk(i_core_clk), .i_resetn(i_resetn), .i_clear(fcr_wr & i_wdata[FCR_RXRST]),
    .i_valid(push_v), .o_ready(rx_ready), .i_data(push_d),
    .o_valid(rx_valid), .i_ready(rhr_rd), .o_data(rx_data), .o_count(rx_count)
  );

  uart_fifo #(.WIDTH(8), .DEPTH(TX_DEPTH)) u_tx_fifo (
    .i_clk(i_core_clk), .i_resetn(i_resetn), .i_clear(fcr_wr & i_wdata[FCR_TXRST]),
    .i_valid(thr_wr), .o_ready(), .i_data(i_wdata),
    .o_valid(tx_valid), .i_ready(tx_take), .o_data(tx_data), .o_count()
  );

  // ************************************************************
  // Transmitter
  // ************************************************************
  wire tx_par = lcr_q[LCR_EPS] ? ^(tx_sh_q & wmask) : ~^(tx_sh_q & wmask);

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tx_st_q <= ST_IDLE;
      tx_cnt_q <= 6'h00;
      tx_bit_q <= 3'h0;
      tx_sh_q <= 8'h00;
      o_tx <= 1'b1;
      sent_pause_q <= 1'b0;
      flow_second_q <= 1'b0;
    end else begin
      o_tx <= (tx_st_q == ST_START) ? 1'b0 : (tx_st_q == ST_DATA) ? tx_sh_q[tx_bit_q] :
              (tx_st_q == ST_PAR) ? tx_par : 1'b1;
      if (fl_pau | fl_res) begin
        sent_pause_q <= fl_pau;
        flow_second_q <= tx_mode == FLOW_DOUBLE;
      end else if (fl_sec) begin
        flow_second_q <= 1'b0;
      end
      if (tx_load) begin
        tx_sh_q <= tx_char;
        tx_cnt_q <= 6'h00;
        tx_bit_q <= 3'h0;
        tx_st_q <= ST_START;
      end else if (tick) begin
        tx_cnt_q <= tx_cnt_q + 6'h01;
        case (tx_st_q)
          ST_IDLE: tx_cnt_q <= 6'h00;
          ST_START: begin
            if (tx_cnt_q == 6'h0f) begin
              tx_cnt_q <= 6'h00;
              tx_st_q <= ST_DATA;
            end
          end
          ST_DATA: begin
            if (tx_cnt_q == 6'h0f) begin
              tx_cnt_q <= 6'h00;
              tx_bit_q <= tx_bit_q + 3'h1;
              if (tx_bit_q == last_bit) tx_st_q <= lcr_q[LCR_PEN] ? ST_PAR : ST_STOP;
            end
          end
          ST_PAR: begin
            if (tx_cnt_q == 6'h0f) begin
              tx_cnt_q <= 6'h00;
              tx_st_q <= ST_STOP;
            end
          end
          ST_STOP: begin
            if (tx_cnt_q == stop_ticks - 6'h01) tx_st_q <= ST_IDLE;
          end
          default: tx_st_q <= ST_IDLE;
        endcase
      end
    end
  end

  // ************************************************************
  // Time-out and interrupt status
  // ************************************************************
  wire [3:0] char_bits = 4'd6 + 4'(wl) + 4'(lcr_q[LCR_PEN]);
  wire [9:0] char_ticks = 10'(char_bits * TICKS_PER_BIT) + 10'(stop_ticks);
  wire [9:0] to_limit = 10'(char_ticks * TIMEOUT_CHARS);
  wire timeout = rx_valid & (to_cnt_q >= to_limit);
  wire ls_p = ier_q[IER_LS] & (oe_q | fe_q);
  wire rx_p = ier_q[IER_RX] & (rx_cnt8 >= trig);
  wire to_p = ier_q[IER_RX] & timeout;
  wire thr_p = ier_q[IER_THR] & thr_pend_q;
  wire [5:0] iid = ls_p ? IID_LS : rx_p ? IID_RX : to_p ? IID_TO : thr_p ? IID_THR :
                   xoff_flag_q ? IID_XOFF : IID_NONE;
  wire thr_on = wr & sel_gen & (i_addr == A_IER) & i_wdata[IER_THR] & !ier_q[IER_THR];
  wire thr_set = (tx_valid_prev_q & !tx_valid) | (thr_on & !tx_valid);
  wire xoff_set = pause_hit & ier_q[IER_PAUSE] | special_hit;
  wire [7:0] line_status_reg = {1'b0, !tx_valid & (tx_st_q == ST_IDLE), !tx_valid, 1'b0, fe_q, 1'b0, oe_q, rx_valid};

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      to_cnt_q <= 10'h000;
      tx_valid_prev_q <= 1'b0;
      thr_pend_q <= 1'b1;
      xoff_flag_q <= 1'b0;
      oe_q <= 1'b0;
      fe_q <= 1'b0;
      o_int <= 1'b0;
    end else begin
      to_cnt_q <= (rx_done_q | rhr_rd | !rx_valid) ? 10'h000 : (tick & !timeout) ? to_cnt_q + 10'h001 : to_cnt_q;
      tx_valid_prev_q <= tx_valid;
      thr_pend_q <= thr_set | (thr_pend_q & !thr_wr & !(isr_rd & iid == IID_THR));
      xoff_flag_q <= xoff_set | (xoff_flag_q & !resume_hit & !(isr_rd & iid == IID_XOFF));
      oe_q <= (push_v & !rx_ready) | (oe_q & !lsr_rd);
      fe_q <= (rx_done_q & !rx_s2_q) | (fe_q & !lsr_rd);
      o_int <= iid != IID_NONE;
    end
  end

  // ************************************************************
  // Read data
  // ************************************************************
  function automatic logic [7:0] rd_gen(input logic [2:0] a);
    case (a)
      A_DATA: rd_gen = rx_data;
      A_IER: rd_gen = ier_q;
      A_ISR: rd_gen = {fcr_q[FCR_EN], fcr_q[FCR_EN], iid};
      A_LCR: rd_gen = lcr_q;
      A_MCR: rd_gen = mcr_q;
      A_LSR: rd_gen = line_status_reg;
      A_SPR: rd_gen = spr_q;
      default: rd_gen = 8'h00;
    endcase
  endfunction

  wire [7:0] rd_mux = sel_div ? (i_addr[0] ? dlm_q : dll_q) : sel_x ? xch_q[i_addr[1:0]] :
                      sel_efr ? efr_q : rd_gen(i_addr);

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata <= 8'h00;
    end else if (rd) begin
      o_rdata <= rd_mux;
    end
  end
endmodule
